// [src/pxp_pkg.sv]
// Constants shared by the port expander target logic.
// Assumes a single 100 MHz clock domain.
package pxp_pkg;
  // Fixed upper address bits (arbitrary value, strap pins give the rest)
  localparam logic [3:0] ADDR_HIGH      = 4'h4;
  localparam int         PORT_COUNT     = 8;
  // Ports come up released high
  localparam logic [7:0] PORT_RESET     = 8'hff;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h8;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam int         SYNC_STAGES    = 2;
  // Bus phases
  typedef enum logic [2:0] {
    PXP_IDLE,
    PXP_ADDR,
    PXP_ADDR_ACK,
    PXP_WR_DATA,
    PXP_WR_ACK,
    PXP_RD_DATA,
    PXP_RD_ACK
  } pxp_state_e;
endpackage : pxp_pkg

// [src/pxp_sync.sv]
// Two-stage synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to CLOCK.
`timescale 1ns/100ps
module pxp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Pin side and synchronised side
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pxp_sync

// [src/pxp_expander.sv]
// Serial-bus target of an eight-port open-drain expander with change alert.
// Assumes SCL, SDA, straps and port pins are asynchronous; synchronised by pxp_sync.
// Function
// - A matching read address is acknowledged and the port levels snapshotted then.
// - After a read byte is sent, transition detection restarts.
// - The alert output is released during the acknowledge after a read byte.
// - A released alert stays inactive until the STOP or repeated START that ends the transfer.
// - Each read byte becomes the new reference for change detection.
// - Further read bytes carry the current port levels again.
// - In a write the address and all data bytes are acknowledged until STOP.
// - Each written byte drives the ports, a zero pulls its port low.
// - Any edge on a port acting as input asserts the alert.
// - Read data are the real pin levels.
// - The address is four fixed bits plus three strap pins.
`timescale 1ns/100ps
module pxp_expander (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  // Serial bus
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OE,
  // Address straps
  input  wire logic [2:0] ADDR_SELECT,
  // Ports, open drain
  input  wire logic [7:0] PORT_PINS_IN,
  output logic      [7:0] PORT_PINS_OE,
  // Change alert, active low open drain
  output logic            ALERT_OE
);
  logic [7:0]           port_sync;
  logic [1:0]           bus_sync;
  logic [2:0]           addr_sync;
  logic                 scl_reg;
  logic                 sda_reg;
  pxp_pkg::pxp_state_e  state_reg;
  logic [3:0]           bit_reg;
  logic [7:0]           shift_reg;
  logic [7:0]           tx_reg;
  logic [7:0]           ref_reg;
  logic [7:0]           out_reg;
  logic                 alert_reg;
  logic                 hold_reg;
  logic                 ack_done_reg;
  logic [7:0]           sent_reg;
  logic [15:0]          watch_pipe_reg;
  logic [7:0]           watch_mask;

  // Pins enter through two flip-flops
  pxp_sync #(.WIDTH(13)) u_sync (
    .clock    (CLOCK),
    .resetn   (RESETN),
    .async_in ({PORT_PINS_IN, SCL_IN, SDA_IN, ADDR_SELECT}),
    .sync_out ({port_sync, bus_sync, addr_sync})
  );

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_match;
  assign scl        = bus_sync[1];
  assign sda        = bus_sync[0];
  assign scl_rise   = scl && !scl_reg;
  assign scl_fall   = !scl && scl_reg;
  assign start_det  = scl && scl_reg && sda_reg && !sda;
  assign stop_det   = scl && scl_reg && !sda_reg && sda;
  assign addr_match = (shift_reg[7:1] == {pxp_pkg::ADDR_HIGH, addr_sync});

  // Edge history of the bus lines
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= scl;
      sda_reg <= sda;
    end
  end

  // Bus phase sequencer, bits sampled on SCL rise, phases advance on SCL fall, a read NACK ends on SCL rise
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= pxp_pkg::PXP_IDLE;
      bit_reg   <= pxp_pkg::BIT_COUNT_ZERO;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      out_reg   <= pxp_pkg::PORT_RESET;
    end
    else if (start_det)
    begin
      state_reg <= pxp_pkg::PXP_ADDR;
      bit_reg   <= pxp_pkg::BIT_COUNT_ZERO;
    end
    else if (stop_det)
      state_reg <= pxp_pkg::PXP_IDLE;
    else
    begin
      if (scl_rise)
      begin
        if (state_reg == pxp_pkg::PXP_ADDR || state_reg == pxp_pkg::PXP_WR_DATA)
        begin
          shift_reg <= {shift_reg[6:0], sda};
          bit_reg   <= bit_reg + 4'h1;
        end
        if (state_reg == pxp_pkg::PXP_ADDR_ACK && shift_reg[0])
          tx_reg <= port_sync;
        if (state_reg == pxp_pkg::PXP_RD_ACK && sda)
          state_reg <= pxp_pkg::PXP_IDLE;
      end
      else if (scl_fall)
      begin
        case (state_reg)
          pxp_pkg::PXP_ADDR:
            if (bit_reg == pxp_pkg::BIT_COUNT_LAST)
              state_reg <= addr_match ? pxp_pkg::PXP_ADDR_ACK : pxp_pkg::PXP_IDLE;
          pxp_pkg::PXP_ADDR_ACK:
          begin
            bit_reg   <= pxp_pkg::BIT_COUNT_ZERO;
            state_reg <= shift_reg[0] ? pxp_pkg::PXP_RD_DATA : pxp_pkg::PXP_WR_DATA;
          end
          pxp_pkg::PXP_WR_DATA:
            if (bit_reg == pxp_pkg::BIT_COUNT_LAST)
            begin
              state_reg <= pxp_pkg::PXP_WR_ACK;
              out_reg   <= shift_reg;
            end
          pxp_pkg::PXP_WR_ACK:
          begin
            bit_reg   <= pxp_pkg::BIT_COUNT_ZERO;
            state_reg <= pxp_pkg::PXP_WR_DATA;
          end
          pxp_pkg::PXP_RD_DATA:
          begin
            tx_reg  <= {tx_reg[6:0], 1'b1};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7)
              state_reg <= pxp_pkg::PXP_RD_ACK;
          end
          pxp_pkg::PXP_RD_ACK:
          begin
            tx_reg    <= port_sync;
            bit_reg   <= pxp_pkg::BIT_COUNT_ZERO;
            state_reg <= pxp_pkg::PXP_RD_DATA;
          end
          default:
            state_reg <= pxp_pkg::PXP_IDLE;
        endcase
      end
    end
  end

  // Data line drive: acknowledge, or a zero data bit while sending
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      SDA_OE <= 1'b0;
    else
    begin
      case (state_reg)
        pxp_pkg::PXP_ADDR_ACK: SDA_OE <= 1'b1;
        pxp_pkg::PXP_WR_ACK:   SDA_OE <= 1'b1;
        pxp_pkg::PXP_RD_DATA:  SDA_OE <= !tx_reg[7];
        pxp_pkg::PXP_RD_ACK:   SDA_OE <= 1'b0;
        default:               SDA_OE <= 1'b0;
      endcase
    end
  end

  // Port drive, a zero bit pulls the port low
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      PORT_PINS_OE <= 8'h00;
    else
      PORT_PINS_OE <= ~out_reg;
  end

  // A port written high reads low until the synchroniser catches up; keep it unwatched till then
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      watch_pipe_reg <= {2{pxp_pkg::PORT_RESET}};
    else
      watch_pipe_reg <= {watch_pipe_reg[7:0], ~PORT_PINS_OE};
  end
  assign watch_mask = out_reg & ~PORT_PINS_OE & watch_pipe_reg[15:8] & watch_pipe_reg[7:0];

  // Change detection against the reference snapshot
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ref_reg      <= pxp_pkg::PORT_RESET;
      alert_reg    <= 1'b0;
      hold_reg     <= 1'b0;
      ack_done_reg <= 1'b0;
    end
    else
    begin
      if (state_reg != pxp_pkg::PXP_RD_ACK)
        ack_done_reg <= 1'b0;
      if (state_reg == pxp_pkg::PXP_RD_ACK && scl_rise && !ack_done_reg)
      begin
        ref_reg      <= sent_reg;
        alert_reg    <= 1'b0;
        hold_reg     <= 1'b1;
        ack_done_reg <= 1'b1;
      end
      else
      begin
        if (stop_det || start_det)
          hold_reg <= 1'b0;
        if (((port_sync & watch_mask) != (ref_reg & watch_mask)) && !hold_reg)
          alert_reg <= 1'b1;
      end
    end
  end

  // Byte put on the wire, same sample as the transmit shifter, kept for the reference update
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      sent_reg <= pxp_pkg::PORT_RESET;
    else if ((scl_fall && state_reg == pxp_pkg::PXP_RD_ACK)
             || (scl_rise && state_reg == pxp_pkg::PXP_ADDR_ACK && shift_reg[0]))
      sent_reg <= port_sync;
  end

  // Alert output, low while a change is pending
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      ALERT_OE <= 1'b0;
    else
      ALERT_OE <= alert_reg && !hold_reg;
  end

  // Acknowledge driven for every matched address
  addr_ack_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state_reg == pxp_pkg::PXP_ADDR_ACK) |=> SDA_OE)
    else $error("address acknowledge not driven");

  // Master acknowledge slot left free
  rd_ack_free_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state_reg == pxp_pkg::PXP_RD_ACK) |=> !SDA_OE)
    else $error("data line held in master acknowledge");

  // Write acknowledge driven
  wr_ack_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state_reg == pxp_pkg::PXP_WR_ACK) |=> SDA_OE)
    else $error("write acknowledge not driven");

  // Ports follow the latched byte
  port_drive_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state_reg == pxp_pkg::PXP_WR_DATA && scl_fall && bit_reg == pxp_pkg::BIT_COUNT_LAST)
    |=> ##1 (PORT_PINS_OE == ~$past(shift_reg, 2)))
    else $error("port drive mismatch");

  // Alert released after a read byte acknowledge
  alert_rel_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state_reg == pxp_pkg::PXP_RD_ACK && scl_rise) |=> ##1 !ALERT_OE)
    else $error("alert not released");

  // Alert held inactive until stop or start
  alert_hold_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (hold_reg && !stop_det && !start_det) |=> !ALERT_OE)
    else $error("alert active before stop");

  // Input edge raises alert
  edge_alert_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (!hold_reg && ((port_sync & watch_mask) != (ref_reg & watch_mask))
     && !(state_reg == pxp_pkg::PXP_RD_ACK && scl_rise)) |=> alert_reg)
    else $error("change not flagged");

  // Reference updated on read acknowledge
  ref_upd_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state_reg == pxp_pkg::PXP_RD_ACK && scl_rise && !ack_done_reg)
    |=> (ref_reg == $past(sent_reg)))
    else $error("reference not refreshed");
endmodule : pxp_expander

// [tb/pxp_master.sv]
// Bus master model for the expander bench.
// Assumes the bench resolves SDA from both pull-downs.
`timescale 1ns/100ps
module pxp_master (
  // Bus
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus, both lines high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Half bit period, well above six clocks
  task automatic hp;
    repeat (10) @(posedge clock);
  endtask : hp
  // SDA falls with SCL high
  task automatic start;
    sda_low <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask : start
  // SDA rises with SCL high, ends the transfer
  task automatic stop;
    sda_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask : stop
  // One bit, set in SCL low, sampled late in SCL high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
  endtask : bit_io
  // Byte MSB first, then the ack slot driven with ma
  task automatic xfer(input logic [7:0] d, input logic ma,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ma, ack);
  endtask : xfer
endmodule : pxp_master

// [tb/pxp_expander_bench.sv]
// Self-checking bench for the expander target.
// Assumes open-drain wires resolve high unless pulled low.
`timescale 1ns/100ps
module pxp_expander_bench;
  logic       CLOCK = 1'b0;
  logic       RESETN = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] ext = 8'hff;
  logic       scl;
  logic       m_low;
  logic       sda_oe;
  logic [7:0] oe;
  logic       alert;
  wire        sda = !(m_low | sda_oe);
  wire  [7:0] pins = ext & ~oe;
  logic [31:0] seed = 32'h9d56a611;
  int         err_count = 0;
  int         n_checks = 0;
  logic [7:0] q;
  logic [7:0] d;
  logic       a;
  always #5 CLOCK = !CLOCK;
  pxp_master i_pxp_master (.clock(CLOCK), .sda(sda), .scl(scl), .sda_low(m_low));
  pxp_expander i_pxp_expander (.CLOCK(CLOCK), .RESETN(RESETN), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OE(sda_oe), .ADDR_SELECT(sel), .PORT_PINS_IN(pins), .PORT_PINS_OE(oe),
    .ALERT_OE(alert));
  // Xorshift source
  function automatic logic [31:0] rnd(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : rnd
  // Pin levels seen with a written byte and external drive
  function automatic logic [7:0] exp_pins(input logic [7:0] e, input logic [7:0] w);
    return e & w;
  endfunction : exp_pins
  // Address byte
  function automatic logic [7:0] adr(input logic rd);
    return {pxp_pkg::ADDR_HIGH, sel, rd};
  endfunction : adr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge CLOCK);
    RESETN <= 1'b1;
    seed = rnd(seed);
    sel <= seed[2:0];
    repeat (4) @(posedge CLOCK);
    chk(oe, 8'h00);
    i_pxp_master.start();
    i_pxp_master.xfer(adr(1'b0) ^ 8'h80, 1'b1, q, a);
    chk(a, 1'b1);
    i_pxp_master.stop();
    $display("test foreign address done");
    i_pxp_master.start();
    i_pxp_master.xfer(adr(1'b0), 1'b1, q, a);
    chk(a, 1'b0);
    seed = rnd(seed);
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 2) ? 8'hf0 : seed[8*i +: 8];
      i_pxp_master.xfer(d, 1'b1, q, a);
      chk(a, 1'b0);
      chk(oe, ~d);
    end
    i_pxp_master.stop();
    $display("test write done");
    chk(alert, 1'b0);
    ext <= 8'h7f;
    repeat (10) @(posedge CLOCK);
    chk(alert, 1'b1);
    i_pxp_master.start();
    i_pxp_master.xfer(adr(1'b1), 1'b1, q, a);
    chk(a, 1'b0);
    ext <= 8'hff;
    i_pxp_master.xfer(8'hff, 1'b0, q, a);
    chk(q, exp_pins(8'h7f, 8'hf0));
    repeat (10) @(posedge CLOCK);
    chk(alert, 1'b0);
    i_pxp_master.xfer(8'hff, 1'b1, q, a);
    chk(q, exp_pins(8'hff, 8'hf0));
    chk(alert, 1'b0);
    i_pxp_master.stop();
    repeat (10) @(posedge CLOCK);
    chk(alert, 1'b0);
    ext <= 8'hbf;
    repeat (10) @(posedge CLOCK);
    chk(alert, 1'b1);
    i_pxp_master.start();
    i_pxp_master.xfer(adr(1'b1), 1'b1, q, a);
    chk(a, 1'b0);
    ext <= 8'hff;
    i_pxp_master.xfer(8'hff, 1'b1, q, a);
    chk(q, exp_pins(8'hbf, 8'hf0));
    chk(a, 1'b1);
    repeat (10) @(posedge CLOCK);
    chk(alert, 1'b0);
    i_pxp_master.stop();
    repeat (10) @(posedge CLOCK);
    chk(alert, 1'b1);
    $display("test read done");
    finish_test();
  end
endmodule : pxp_expander_bench
